/* File: hdl/wiper_host.sv */
`timescale 1ns/1ns
module wiper_host #(
   parameter int store_deselect_cycles = wiper_host_pkg::store_deselect_cyc,
   parameter int powerup_cycles = wiper_host_pkg::powerup_cyc
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic clk_link_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_up_i,
   input wire logic [wiper_host_pkg::steps_width-1:0] cmd_steps_i,
   input wire logic cmd_store_i,
   output logic busy_o,
   output logic done_o,
   output logic [wiper_host_pkg::pos_width-1:0] pos_est_o,
   output logic select_n_o,
   output logic strobe_n_o,
   output logic dir_up_o
);
   localparam int cnt_w = 32;
   // link-domain reset, released synchronously
   logic lrst_a_q;
   logic lrst_q;
   always_ff @(posedge clk_link_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         lrst_a_q <= 1'b1;
         lrst_q <= 1'b1;
      end
      else
      begin
         lrst_a_q <= 1'b0;
         lrst_q <= lrst_a_q;
      end
   end

   // command handshake: toggle request, toggle acknowledge
   logic req_tog_q;
   logic ack_tog_q;
   logic ack_s1_q;
   logic ack_s2_q;
   logic ack_s3_q;
   logic pend_q;
   logic up_q;
   logic store_q;
   logic [wiper_host_pkg::steps_width-1:0] steps_q;
   logic [wiper_host_pkg::pos_width-1:0] pos_q;
   logic done_q;
   wire accept = cmd_valid_i && !pend_q;
   wire ack_seen = ack_s2_q ^ ack_s3_q;
   assign cmd_ready_o = !pend_q;
   assign busy_o = pend_q;
   assign done_o = done_q;
   assign pos_est_o = pos_q;

   // estimate of wiper position, starts at zero since the device is never read; saturates like the device
   wire [7:0] pos_sum = cmd_up_i ? ({1'b0, pos_q} + {1'b0, cmd_steps_i}) : 8'h00;
   wire [wiper_host_pkg::pos_width-1:0] pos_top = 7'(wiper_host_pkg::tap_count - 1);
   wire [wiper_host_pkg::pos_width-1:0] pos_next = cmd_up_i
      ? ((pos_sum > {1'b0, pos_top}) ? pos_top : pos_sum[6:0])
      : ((cmd_steps_i > pos_q) ? 7'h00 : pos_q - cmd_steps_i);

   // system side holds command fields stable while pending
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         req_tog_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
         pend_q <= 1'b0;
         up_q <= 1'b0;
         store_q <= 1'b0;
         steps_q <= 7'h00;
         pos_q <= 7'h00;
         done_q <= 1'b0;
      end
      else
      begin
         ack_s1_q <= ack_tog_q;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
         done_q <= pend_q && ack_seen;
         if (accept)
         begin
            req_tog_q <= !req_tog_q;
            pend_q <= 1'b1;
            up_q <= cmd_up_i;
            store_q <= cmd_store_i;
            steps_q <= cmd_steps_i;
            pos_q <= pos_next;
         end
         else if (ack_seen)
         begin
            pend_q <= 1'b0;
         end
      end
   end

   // link side: request synchroniser and pin sequencer
   // two flops before the sequencer reads the request
   logic req_s1_q;
   logic req_s2_q;
   wiper_host_pkg::link_state_type st_q;
   wiper_host_pkg::link_state_type st_d;
   logic [cnt_w-1:0] cnt_q;
   logic [cnt_w-1:0] cnt_d;
   logic [wiper_host_pkg::steps_width-1:0] left_q;
   logic [wiper_host_pkg::steps_width-1:0] left_d;
   logic sel_q;
   logic sel_d;
   logic stb_q;
   logic stb_d;
   logic dir_q;
   logic dir_d;
   logic ack_d;
   logic stored_q;
   logic stored_d;
   // level compare against ack, so a request landing in a gap waits instead of being lost
   wire new_req = req_s2_q ^ ack_tog_q;
   wire cnt_zero = (cnt_q == '0);
   assign select_n_o = sel_q;
   assign strobe_n_o = stb_q;
   assign dir_up_o = dir_q;

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
      left_d = left_q;
      sel_d = sel_q;
      stb_d = stb_q;
      dir_d = dir_q;
      ack_d = ack_tog_q;
      stored_d = stored_q;
      case (st_q)
         // hold off until device spec applies
         wiper_host_pkg::st_powerup_type_v:
            if (cnt_zero)
               st_d = wiper_host_pkg::st_idle;
         wiper_host_pkg::st_idle:
            if (new_req && cnt_zero)
            begin
               left_d = steps_q;
               sel_d = 1'b0;
               cnt_d = cnt_w'(wiper_host_pkg::select_setup_cyc);
               st_d = wiper_host_pkg::st_select;
            end
         wiper_host_pkg::st_select:
            if (cnt_zero)
            begin
               dir_d = up_q;
               cnt_d = cnt_w'(wiper_host_pkg::dir_setup_cyc);
               st_d = wiper_host_pkg::st_dir;
            end
         wiper_host_pkg::st_dir:
            if (cnt_zero)
            begin
               if (left_q == 7'h00)
               begin
                  // strobe idle long enough before select rises
                  cnt_d = cnt_w'(wiper_host_pkg::strobe_to_deselect_cyc);
                  st_d = wiper_host_pkg::st_pre_deselect;
               end
               else
               begin
                  stb_d = 1'b0;
                  left_d = left_q - 1'b1;
                  cnt_d = cnt_w'(wiper_host_pkg::strobe_low_cyc);
                  st_d = wiper_host_pkg::st_low;
               end
            end
         wiper_host_pkg::st_low:
            if (cnt_zero)
            begin
               if (left_q == 7'h00 && !store_q)
               begin
                  // last pulse stays low through deselect, so no extra step
                  cnt_d = cnt_w'(wiper_host_pkg::dir_change_cyc);
                  st_d = wiper_host_pkg::st_pre_deselect;
               end
               else
               begin
                  stb_d = 1'b1;
                  // high time covers the direction hold too
                  cnt_d = cnt_w'(wiper_host_pkg::strobe_high_cyc);
                  st_d = wiper_host_pkg::st_dir;
               end
            end
         wiper_host_pkg::st_pre_deselect:
            if (cnt_zero)
            begin
               // strobe low at deselect skips the store
               // strobe level decides; zero steps cannot avoid a store without a stray step
               stored_d = stb_q;
               cnt_d = cnt_w'(wiper_host_pkg::dir_change_cyc);
               st_d = wiper_host_pkg::st_high;
            end
         wiper_host_pkg::st_high:
            if (cnt_zero)
            begin
               // select rises, strobe high means store
               sel_d = 1'b1;
               cnt_d = cnt_w'(wiper_host_pkg::dir_change_cyc);
               st_d = wiper_host_pkg::st_deselect;
            end
         wiper_host_pkg::st_deselect:
            if (cnt_zero)
            begin
               stb_d = 1'b1;
               ack_d = !ack_tog_q;
               // gap depends on whether a store ran
               cnt_d = stored_q ? cnt_w'(store_deselect_cycles)
                                : cnt_w'(wiper_host_pkg::nostore_deselect_cyc);
               st_d = wiper_host_pkg::st_idle;
            end
         default:
            st_d = wiper_host_pkg::st_idle;
      endcase
   end

   // pins idle high straight out of reset
   always_ff @(posedge clk_link_i or posedge lrst_q)
   begin
      if (lrst_q)
      begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         st_q <= wiper_host_pkg::st_powerup_type_v;
         cnt_q <= cnt_w'(powerup_cycles);
         left_q <= 7'h00;
         sel_q <= 1'b1;
         stb_q <= 1'b1;
         dir_q <= 1'b1;
         ack_tog_q <= 1'b0;
         stored_q <= 1'b0;
      end
      else
      begin
         req_s1_q <= req_tog_q;
         req_s2_q <= req_s1_q;
         st_q <= st_d;
         cnt_q <= cnt_d;
         left_q <= left_d;
         sel_q <= sel_d;
         stb_q <= stb_d;
         dir_q <= dir_d;
         ack_tog_q <= ack_d;
         stored_q <= stored_d;
      end
   end
endmodule : wiper_host

/* File: hdl/wiper_host_pkg.sv */
package wiper_host_pkg;
   localparam int clk_period_ns = 20;
   localparam int link_period_ns = 6;
   // pin timing, figures in their own units
   localparam int store_deselect_time_ms = 20;
   localparam int nostore_deselect_time_us = 1;
   localparam int strobe_to_deselect_time_us = 1;
   localparam int strobe_high_to_dir_change_ns = 100;
   localparam int powerup_settle_time_us = 500;
   localparam int powerup_spec_time_ms = 1;
   localparam int strobe_low_time_us = 1;
   localparam int strobe_high_time_us = 1;
   localparam int dir_to_strobe_setup_us = 1;
   localparam int select_to_strobe_setup_ns = 100;
   // minimum times round up to whole link cycles
   localparam int store_deselect_cyc = (store_deselect_time_ms * 1000000 + link_period_ns - 1) / link_period_ns;
   localparam int nostore_deselect_cyc = (nostore_deselect_time_us * 1000 + link_period_ns - 1) / link_period_ns;
   localparam int strobe_to_deselect_cyc = (strobe_to_deselect_time_us * 1000 + link_period_ns - 1) / link_period_ns;
   localparam int dir_change_cyc = (strobe_high_to_dir_change_ns + link_period_ns - 1) / link_period_ns;
   localparam int powerup_cyc = (powerup_spec_time_ms * 1000000 + link_period_ns - 1) / link_period_ns;
   localparam int strobe_low_cyc = (strobe_low_time_us * 1000 + link_period_ns - 1) / link_period_ns;
   localparam int strobe_high_cyc = (strobe_high_time_us * 1000 + link_period_ns - 1) / link_period_ns;
   localparam int dir_setup_cyc = (dir_to_strobe_setup_us * 1000 + link_period_ns - 1) / link_period_ns;
   localparam int select_setup_cyc = (select_to_strobe_setup_ns + link_period_ns - 1) / link_period_ns;
   localparam int tap_count = 100;
   localparam int pos_width = 7;
   localparam int steps_width = 7;
   typedef enum logic [3:0] {
      st_powerup_type_v,
      st_idle,
      st_select,
      st_dir,
      st_low,
      st_high,
      st_pre_deselect,
      st_deselect
   } link_state_type;
endpackage : wiper_host_pkg

/* File: sim/wiper_host_sva.sv */
`timescale 1ns/1ns
module wiper_host_sva #(
   parameter int store_deselect_cycles = 50,
   parameter int powerup_cycles = 20
) (
   input wire logic clk_link_i,
   input wire logic reset_i,
   input wire logic select_n_o,
   input wire logic strobe_n_o,
   input wire logic dir_up_o
);
   logic [31:0] sel_hi_q;
   logic [31:0] stb_hi_q;
   logic stored_q;
   logic first_q;
   // idle run lengths; stored_q keeps strobe level seen while selected
   always_ff @(posedge clk_link_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sel_hi_q <= 32'h0;
         stb_hi_q <= 32'h0;
         stored_q <= 1'b0;
         first_q <= 1'b1;
      end
      else
      begin
         sel_hi_q <= select_n_o ? sel_hi_q + 32'h1 : 32'h0;
         stb_hi_q <= strobe_n_o ? stb_hi_q + 32'h1 : 32'h0;
         first_q <= first_q & select_n_o;
         stored_q <= select_n_o ? stored_q : strobe_n_o;
      end
   end
   default clocking @(posedge clk_link_i); endclocking
   default disable iff (reset_i);
   // a new selection other than the first after reset
   sequence reselect;
      $fell(select_n_o) && !first_q;
   endsequence
   a_store_gap: assert property (reselect ##0 stored_q |-> sel_hi_q >= store_deselect_cycles)
      else $error("short gap after store");
   a_nostore_gap: assert property (reselect ##0 !stored_q |-> sel_hi_q >= wiper_host_pkg::nostore_deselect_cyc)
      else $error("short gap without store");
   a_strobe_desel: assert property ($rose(select_n_o) && strobe_n_o |->
      stb_hi_q >= wiper_host_pkg::strobe_to_deselect_cyc) else $error("deselect too soon after strobe");
   a_dir_hold: assert property ($changed(dir_up_o) |-> strobe_n_o && stb_hi_q >= wiper_host_pkg::dir_change_cyc)
      else $error("direction changed too early");
   a_idle_high: assert property (first_q |-> strobe_n_o) else $error("strobe low before first select");
   a_powerup_wait: assert property ($fell(select_n_o) && first_q |-> sel_hi_q >= powerup_cycles)
      else $error("selected before power-up wait");
   a_strobe_sel: assert property ($fell(strobe_n_o) |-> !select_n_o [*8]) else $error("strobe fell unselected");
endmodule : wiper_host_sva
bind wiper_host wiper_host_sva #(.store_deselect_cycles(store_deselect_cycles), .powerup_cycles(powerup_cycles)) u_sva (
   .clk_link_i(clk_link_i), .reset_i(reset_i), .select_n_o(select_n_o), .strobe_n_o(strobe_n_o), .dir_up_o(dir_up_o));

/* File: sim/wiper_device_model.sv */
`timescale 1ns/1ns
module wiper_device_model #(
   parameter logic [6:0] stored_init = 7'h3c
) (
   input wire logic select_n_i,
   input wire logic strobe_n_i,
   input wire logic dir_up_i,
   output logic [6:0] count_o,
   output logic [6:0] nv_o
);
   initial
   begin
      nv_o = stored_init;
      count_o = stored_init;
   end
   always @(negedge strobe_n_i)
   begin
      if (!select_n_i && dir_up_i && count_o < 7'h63) count_o = count_o + 7'h01;
      else if (!select_n_i && !dir_up_i && count_o > 7'h00) count_o = count_o - 7'h01;
   end
   always @(posedge select_n_i)
   begin
      if (strobe_n_i === 1'b1) nv_o = count_o;
   end
endmodule : wiper_device_model

/* File: sim/wiper_host_test.sv */
`timescale 1ns/1ns
module wiper_host_test;
   logic clk_sys_i = 1'b0;
   logic clk_link_i = 1'b0;
   logic reset_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   logic cmd_up_i = 1'b0;
   logic [6:0] cmd_steps_i = 7'h00;
   logic cmd_store_i = 1'b0;
   logic cmd_ready_o, busy_o, done_o, select_n_o, strobe_n_o, dir_up_o;
   logic [6:0] pos_est_o, dev_count, dev_nv;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   // clocks; link phase offset by 1 ns, yet rising edges still coincide every 60 ns
   initial forever #10 clk_sys_i = ~clk_sys_i;
   initial
   begin
      #1;
      forever #3 clk_link_i = ~clk_link_i;
   end
   wiper_host #(.store_deselect_cycles(50), .powerup_cycles(20)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .clk_link_i(clk_link_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_up_i(cmd_up_i),
      .cmd_steps_i(cmd_steps_i), .cmd_store_i(cmd_store_i), .busy_o(busy_o), .done_o(done_o),
      .pos_est_o(pos_est_o), .select_n_o(select_n_o), .strobe_n_o(strobe_n_o), .dir_up_o(dir_up_o));
   wiper_device_model model (.select_n_i(select_n_o), .strobe_n_i(strobe_n_o), .dir_up_i(dir_up_o),
      .count_o(dev_count), .nv_o(dev_nv));
   task automatic check(input logic [6:0] got, input logic [6:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic results;
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // hang guard, runs need about 6000 cycles
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         results();
      end
   end
   // offer one command, check it is busy, wait for done
   task automatic run_cmd(input logic up, input logic [6:0] steps, input logic store);
      @(posedge clk_sys_i);
      cmd_valid_i <= 1'b1;
      cmd_up_i <= up;
      cmd_steps_i <= steps;
      cmd_store_i <= store;
      @(negedge clk_sys_i);
      while (cmd_ready_o !== 1'b1) @(negedge clk_sys_i);
      @(posedge clk_sys_i);
      cmd_valid_i <= 1'b0;
      @(negedge clk_sys_i);
      check({6'h00, cmd_ready_o}, 7'h00);
      check({6'h00, busy_o}, 7'h01);
      while (done_o !== 1'b1) @(negedge clk_sys_i);
      check({6'h00, busy_o}, 7'h00);
   endtask : run_cmd
   // five down, no store: stored copy keeps old value
   task automatic t_down_nostore;
      run_cmd(1'b0, 7'h05, 1'b0);
      check(dev_count, 7'h37);
      check(dev_nv, 7'h3c);
      check(pos_est_o, 7'h00);
   endtask : t_down_nostore
   // fifty up runs past the top, then stored
   task automatic t_up_store;
      run_cmd(1'b1, 7'h32, 1'b1);
      check(dev_count, 7'h63);
      check(dev_nv, 7'h63);
      check(pos_est_o, 7'h32);
   endtask : t_up_store
   // zero steps right after a store: select and deselect only, strobe stays high
   task automatic t_zero_steps;
      run_cmd(1'b0, 7'h00, 1'b0);
      check(dev_count, 7'h63);
      check(dev_nv, 7'h63);
      check(pos_est_o, 7'h32);
   endtask : t_zero_steps
   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      t_down_nostore();
      t_up_store();
      t_zero_steps();
      results();
   end
endmodule : wiper_host_test
